/* logic/dcc_pkg.sv */
package dcc_pkg;
    localparam int NSUB = 4;
    localparam int NSRC = 6;
    localparam logic [7:0] A_BAND = 8'h00;
    localparam logic [7:0] A_CTL  = 8'h04;
    localparam logic [7:0] A_MODE = 8'h14;
    localparam logic [7:0] A_CNT  = 8'h18;
    localparam logic [7:0] A_DST  = 8'h28;
    localparam logic [7:0] A_STAT = 8'h30;
    localparam int B_FAE   = 14;
    localparam int B_ACK   = 8;
    localparam int B_EN    = 4;
    localparam int B_IE    = 0;
    localparam int B_SIZE  = 7;
    localparam int B_DIR   = 6;
    localparam int B_ALLOW = 5;
    localparam int B_RPE   = 5;
    localparam logic [15:0] BAND_RST = 16'h0000;
    localparam logic [7:0]  CTL_RST  = 8'h00;
    localparam logic [15:0] CNT_RST  = 16'h0000;
    localparam logic [23:0] DST_RST  = 24'h000000;
    localparam logic [23:0] STEP_B   = 24'h000001;
    localparam logic [23:0] STEP_W   = 24'h000002;
    localparam logic [3:0] C_AD  = 4'h1;
    localparam logic [3:0] C_USB = 4'h3;
    localparam logic [3:0] C_TX  = 4'h4;
    localparam logic [3:0] C_RX  = 4'h5;
    localparam logic [3:0] C_ACS = 4'h6;
    localparam logic [3:0] C_ABU = 4'h7;
    localparam logic [3:0] C_TM0 = 4'h8;
    localparam logic [3:0] C_TM1 = 4'h9;
    localparam logic [3:0] C_TM2 = 4'hA;
    localparam logic [2:0] SRC_NONE = 3'h7;

    typedef struct packed {
        logic [15:0]      band;
        logic [3:0][7:0]  ctl;
        logic [1:0]       blk;
        logic [3:0][15:0] cnt;
        logic [1:0][23:0] dst;
        logic [3:0]       rd0;
        logic [3:0]       pend;
        logic [5:0]       irq_q;
        logic [1:0]       usb_sy;
        logic [1:0]       csph;
        logic [31:0]      rdata;
        logic             ready;
        logic             err;
        logic [5:0]       clr;
        logic [5:0]       cpu;
        logic [3:0]       endi;
        logic [3:0]       done;
    } dcc_st_t;

    function automatic logic [2:0] src_idx(input logic [3:0] code);
        case (code)
            C_AD:    src_idx = 3'h0;
            C_TX:    src_idx = 3'h1;
            C_RX:    src_idx = 3'h2;
            C_TM0:   src_idx = 3'h3;
            C_TM1:   src_idx = 3'h4;
            C_TM2:   src_idx = 3'h5;
            default: src_idx = SRC_NONE;
        endcase
    endfunction : src_idx
endpackage : dcc_pkg

/* logic/dcc_ctrl.sv */
`timescale 1ns/1ps
module dcc_ctrl (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [5:0]  periph_irq,
    input  wire logic        usb_request_line_n,
    output logic      [5:0]  periph_clear,
    output logic      [5:0]  cpu_irq_req,
    output logic      [3:0]  end_irq,
    output logic      [3:0]  xfer_done
);
    dcc_pkg::dcc_st_t r;
    dcc_pkg::dcc_st_t n;

    logic [3:0]      full;
    logic [3:0]      act;
    logic [3:0]      en;
    logic [3:0]      ie;
    logic [3:0]      ack;
    logic [3:0]      pv;
    logic [3:0]      uv;
    logic [3:0]      ab;
    logic [3:0]      acs;
    logic [3:0]      rq;
    logic [3:0]      evt;
    logic [3:0]      rpt;
    logic [3:0]      smask;
    logic [3:0][2:0] sidx;
    logic [3:0][3:0] code;
    logic            g_v;
    logic [1:0]      g_s;

    genvar gs;
    for (gs = 0; gs < dcc_pkg::NSUB; gs++)
    begin : g_sub
        localparam int C = gs / 2;
        // Wide mode joins A and B; the odd sub then only lends its bits
        assign full[gs]  = r.band[dcc_pkg::B_FAE + C];
        assign act[gs]   = !full[gs] || (gs % 2 == 0);
        assign en[gs]    = r.band[dcc_pkg::B_EN + gs];
        assign ie[gs]    = r.band[dcc_pkg::B_IE + gs];
        assign ack[gs]   = full[gs] ? r.band[dcc_pkg::B_ACK + 2 * C + 1] : r.band[dcc_pkg::B_ACK + gs];
        assign code[gs]  = full[gs] ? r.ctl[2 * C + 1][3:0] : r.ctl[gs][3:0];
        assign sidx[gs]  = dcc_pkg::src_idx(code[gs]);
        // Peripheral sources in short and block mode; USB in wide modes
        assign pv[gs]    = (!full[gs] || r.blk[C]) && sidx[gs] != dcc_pkg::SRC_NONE;
        assign uv[gs]    = full[gs] && code[gs] == dcc_pkg::C_USB;
        assign ab[gs]    = full[gs] && !r.blk[C] && code[gs] == dcc_pkg::C_ABU;
        assign acs[gs]   = full[gs] && !r.blk[C] && code[gs] == dcc_pkg::C_ACS;
        assign rpt[gs]   = !full[gs] && r.ctl[gs][dcc_pkg::B_RPE] && !ie[gs];
        // New source event latches only while enabled
        assign evt[gs]   = act[gs] && en[gs] && pv[gs] && periph_irq[sidx[gs]] && !r.irq_q[sidx[gs]];
        // Unassigned codes match none of the request terms
        assign rq[gs]    = act[gs] && en[gs] && ((r.pend[gs] && pv[gs]) || (uv[gs] && !r.usb_sy[1])
                           || ab[gs] || (acs[gs] && r.csph[C]));
        // Ack only counts on an enabled sub; master enable plays no part
        assign smask[gs] = act[gs] && en[gs] && ack[gs] && pv[gs];
    end

    always_comb
    begin
        logic [7:0]  off;
        logic [1:0]  ix;
        logic [23:0] step;
        logic        ch;
        off  = paddr - dcc_pkg::A_CTL;
        ix   = 2'b00;
        step = dcc_pkg::STEP_B;
        ch   = 1'b0;
        n    = r;
        n.done   = 4'h0;
        n.clr    = 6'h00;
        n.ready  = 1'b0;
        n.err    = 1'b0;
        n.usb_sy = {r.usb_sy[0], usb_request_line_n};
        n.irq_q  = periph_irq;
        n.csph   = ~r.csph;
        if (psel && !penable)
        begin
            n.ready = 1'b1;
            n.rdata = 32'h00000000;
            if (paddr == dcc_pkg::A_BAND)
            begin
                n.rdata = {16'h0000, r.band};
                if (!pwrite)
                    n.rd0 = r.rd0 | ~r.band[dcc_pkg::B_EN +: 4];
            end
            else if (paddr >= dcc_pkg::A_CTL && paddr < dcc_pkg::A_MODE && paddr[1:0] == 2'b00)
                n.rdata = {24'h000000, r.ctl[off[3:2]]};
            else if (paddr == dcc_pkg::A_MODE)
                n.rdata = {30'h00000000, r.blk};
            else if (paddr >= dcc_pkg::A_CNT && paddr < dcc_pkg::A_DST && paddr[1:0] == 2'b00)
            begin
                off     = paddr - dcc_pkg::A_CNT;
                n.rdata = {16'h0000, r.cnt[off[3:2]]};
            end
            else if (paddr >= dcc_pkg::A_DST && paddr < dcc_pkg::A_STAT && paddr[1:0] == 2'b00)
                n.rdata = {8'h00, r.dst[paddr[2]]};
            else if (paddr == dcc_pkg::A_STAT)
                n.rdata = {28'h0000000, r.pend};
            else
                n.err = 1'b1;
        end
        if (psel && penable && r.ready && pwrite && !r.err)
        begin
            if (paddr == dcc_pkg::A_BAND)
            begin
                // Reserved bits are stored and read back as written
                n.band = pwdata[15:0];
                for (int s = 0; s < dcc_pkg::NSUB; s++)
                    n.band[dcc_pkg::B_EN + s] = pwdata[dcc_pkg::B_EN + s] && (en[s] || r.rd0[s]);
                n.rd0 = 4'h0;
            end
            else if (paddr >= dcc_pkg::A_CTL && paddr < dcc_pkg::A_MODE)
            begin
                ix = off[3:2];
                n.ctl[ix] = pwdata[7:0];
            end
            else if (paddr == dcc_pkg::A_MODE)
                n.blk = pwdata[1:0];
            else if (paddr >= dcc_pkg::A_CNT && paddr < dcc_pkg::A_DST)
            begin
                off = paddr - dcc_pkg::A_CNT;
                n.cnt[off[3:2]] = pwdata[15:0];
            end
            else if (paddr >= dcc_pkg::A_DST && paddr < dcc_pkg::A_STAT)
                n.dst[paddr[2]] = pwdata[23:0];
        end
        for (int s = 0; s < dcc_pkg::NSUB; s++)
            if (evt[s])
                n.pend[s] = 1'b1;
        // Lowest index wins; shared sources go in priority order
        g_v = 1'b0;
        g_s = 2'b00;
        for (int s = dcc_pkg::NSUB - 1; s >= 0; s--)
            if (rq[s])
            begin
                g_v = 1'b1;
                g_s = s[1:0];
            end
        if (g_v)
        begin
            // Set wins over the grant's clear
            if (!evt[g_s])
                n.pend[g_s] = 1'b0;
            n.done[g_s] = 1'b1;
            if (rpt[g_s])
                n.cnt[g_s][7:0] = (r.cnt[g_s][7:0] == 8'h01) ? r.cnt[g_s][15:8] : r.cnt[g_s][7:0] - 8'h01;
            else
            begin
                n.cnt[g_s] = r.cnt[g_s] - 16'h0001;
                if (r.cnt[g_s] == 16'h0001)
                    n.band[dcc_pkg::B_EN + g_s] = 1'b0;
            end
            if (full[g_s])
            begin
                ch = g_s[1];
                if (r.ctl[g_s][dcc_pkg::B_SIZE])
                    step = dcc_pkg::STEP_W;
                if (r.ctl[{ch, 1'b1}][dcc_pkg::B_ALLOW])
                    n.dst[ch] = r.ctl[{ch, 1'b1}][dcc_pkg::B_DIR] ? r.dst[ch] - step : r.dst[ch] + step;
            end
            if (pv[g_s] && ack[g_s])
                n.clr[sidx[g_s]] = 1'b1;
        end
        for (int k = 0; k < dcc_pkg::NSRC; k++)
        begin
            n.cpu[k] = periph_irq[k];
            for (int s = 0; s < dcc_pkg::NSUB; s++)
                if (smask[s] && sidx[s] == k[2:0])
                    n.cpu[k] = 1'b0;
        end
        for (int s = 0; s < dcc_pkg::NSUB; s++)
        begin
            n.endi[s] = act[s] && ie[s] && !en[s];
            if (!en[s])
                n.pend[s] = 1'b0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            r      <= '0;
            r.band <= dcc_pkg::BAND_RST;
            r.ctl  <= {4{dcc_pkg::CTL_RST}};
            r.cnt  <= {4{dcc_pkg::CNT_RST}};
            r.dst  <= {2{dcc_pkg::DST_RST}};
            r.usb_sy <= 2'b11;
        end
        else
            r <= n;
    end

    assign prdata       = r.rdata;
    assign pready       = r.ready;
    assign pslverr      = r.err;
    assign periph_clear = r.clr;
    assign cpu_irq_req  = r.cpu;
    assign end_irq      = r.endi;
    assign xfer_done    = r.done;

    // Checks
    logic [23:0] dst_sel;
    logic [23:0] step_sel;
    logic        hold_c;
    logic        inc_c;
    logic [2:0]  sidx_g;
    assign dst_sel  = r.dst[g_s[1]];
    assign step_sel = r.ctl[g_s][dcc_pkg::B_SIZE] ? dcc_pkg::STEP_W : dcc_pkg::STEP_B;
    assign hold_c   = g_v && full[g_s] && !r.ctl[{g_s[1], 1'b1}][dcc_pkg::B_ALLOW];
    assign inc_c    = g_v && full[g_s] && r.ctl[{g_s[1], 1'b1}][dcc_pkg::B_ALLOW]
                      && !r.ctl[{g_s[1], 1'b1}][dcc_pkg::B_DIR];
    assign sidx_g   = sidx[g_s];

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    property p_dst_hold;
        hold_c |=> r.dst[$past(g_s[1])] == $past(dst_sel);
    endproperty
    a_dst_hold: assert property (p_dst_hold) else $error("dest moved while fixed");

    property p_dst_inc;
        inc_c |=> r.dst[$past(g_s[1])] == 24'($past(dst_sel) + $past(step_sel));
    endproperty
    a_dst_inc: assert property (p_dst_inc) else $error("dest step wrong");

    property p_one;
        $onehot0(xfer_done);
    endproperty
    a_one: assert property (p_one) else $error("two transfers at once");

    property p_clr;
        g_v && pv[g_s] && ack[g_s] |=> periph_clear[$past(sidx_g)];
    endproperty
    a_clr: assert property (p_clr) else $error("source not cleared");

    for (gs = 0; gs < dcc_pkg::NSUB; gs++)
    begin : g_chk
        property p_prio;
            rq[gs] && !(|(rq & 4'((1 << gs) - 1))) |=> xfer_done[gs];
        endproperty
        a_prio: assert property (p_prio) else $error("priority request not served");

        property p_off;
            !(act[gs] && en[gs]) |=> !xfer_done[gs];
        endproperty
        a_off: assert property (p_off) else $error("disabled sub transferred");

        property p_mask;
            smask[gs] |=> !cpu_irq_req[$past(sidx[gs])];
        endproperty
        a_mask: assert property (p_mask) else $error("acked source reached cpu");

        property p_end;
            act[gs] && ie[gs] && !en[gs] |=> end_irq[gs];
        endproperty
        a_end: assert property (p_end) else $error("end interrupt missing");

        property p_fin;
            g_v && g_s == gs && !rpt[gs] && r.cnt[gs] == 16'h0001 |=> !en[gs] ##1 !xfer_done[gs];
        endproperty
        a_fin: assert property (p_fin) else $error("enable kept at count end");

        property p_set;
            $rose(en[gs]) |-> $past(r.rd0[gs]);
        endproperty
        a_set: assert property (p_set) else $error("enable set without read");

        property p_unas;
            act[gs] && en[gs] && !(pv[gs] || uv[gs] || ab[gs] || acs[gs]) |=> !xfer_done[gs];
        endproperty
        a_unas: assert property (p_unas) else $error("unassigned code transferred");
    end

    c_usb: cover property (g_v && uv[g_s]);
    c_burst: cover property (g_v && ab[g_s] ##1 g_v && ab[g_s]);
    c_fin: cover property (g_v && r.cnt[g_s] == 16'h0001);
    c_end: cover property (|end_irq);
endmodule : dcc_ctrl

/* dv/dcc_periph_model.sv */
`timescale 1ns/1ps
module dcc_periph_model (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic [5:0] fire,
    input  wire logic [5:0] clr,
    input  wire logic       usb_req,
    output logic      [5:0] periph_irq,
    output logic            usb_request_line_n
);
    // Source flags stay set until the transfer or software clears them
    always_ff @(posedge core_clk)
    begin
        if (rst)
            periph_irq <= 6'h00;
        else
            periph_irq <= (periph_irq & ~clr) | fire;
    end
    // Request pulls the line low
    assign usb_request_line_n = ~usb_req;
endmodule : dcc_periph_model

/* dv/test_dcc_ctrl.sv */
`timescale 1ns/1ps
module test_dcc_ctrl;
    logic        core_clk = 1'b0;
    logic        rst;
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [5:0]  periph_irq;
    logic        usb_n;
    logic [5:0]  periph_clear;
    logic [5:0]  cpu_irq_req;
    logic [3:0]  end_irq;
    logic [3:0]  xfer_done;
    logic [5:0]  fire;
    logic [5:0]  sclr;
    logic        usb;
    logic [31:0] rd;
    logic        er;
    logic [23:0] e;
    logic [23:0] st;
    int          error_cnt;
    int          n_checks;
    int          q[$];
    int          tq[$];
    int          ccnt;
    int          ncyc;
    logic [3:0]  bc[6] = '{dcc_pkg::C_AD, dcc_pkg::C_TX, dcc_pkg::C_RX,
                           dcc_pkg::C_TM0, dcc_pkg::C_TM1, dcc_pkg::C_TM2};
    logic [3:0]  uc[4] = '{4'h0, 4'h2, 4'hB, 4'hF};

    always #5 core_clk = ~core_clk;

    dcc_ctrl i_dut (.core_clk(core_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .periph_irq(periph_irq), .usb_request_line_n(usb_n), .periph_clear(periph_clear),
        .cpu_irq_req(cpu_irq_req), .end_irq(end_irq), .xfer_done(xfer_done));

    dcc_periph_model i_model (.core_clk(core_clk), .rst(rst), .fire(fire), .clr(periph_clear | sclr),
        .usb_req(usb), .periph_irq(periph_irq), .usb_request_line_n(usb_n));

    // Records transfers and source clears
    always @(posedge core_clk)
    begin
        ncyc++;
        for (int i = 0; i < 4; i++)
            if (xfer_done[i] === 1'b1)
            begin
                q.push_back(i);
                tq.push_back(ncyc);
            end
        for (int i = 0; i < 6; i++)
            if (periph_clear[i] === 1'b1)
                ccnt++;
    end

    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_checks++;
        if (g !== x)
        begin
            error_cnt++;
            $display("FAIL %0t got %h expected %h", $time, g, x);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1)
            @(posedge core_clk);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(rd, x);
    endtask : rdc

    task automatic en(input logic [31:0] v);
        apb(1'b0, dcc_pkg::A_BAND, 32'h0);
        wr(dcc_pkg::A_BAND, v);
    endtask : en

    task automatic pulse(input logic [5:0] f, input logic [5:0] c);
        @(posedge core_clk);
        fire <= f;
        sclr <= c;
        @(posedge core_clk);
        fire <= 6'h00;
        sclr <= 6'h00;
    endtask : pulse

    task automatic go(input logic [5:0] m);
        repeat (4) @(posedge core_clk);
        q.delete();
        ccnt = 0;
        pulse(m, 6'h00);
        repeat (8) @(posedge core_clk);
    endtask : go

    initial
    begin
        #300000;
        error_cnt++;
        finish_test();
    end

    initial
    begin
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
        fire = 6'h00; sclr = 6'h00; usb = 1'b0; error_cnt = 0; n_checks = 0; ccnt = 0; ncyc = 0;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        rdc(dcc_pkg::A_BAND, 32'h0);
        rdc(dcc_pkg::A_CTL, 32'h0);
        apb(1'b0, 8'hFC, 32'h0);
        chk(er, 1'b1);
        wr(dcc_pkg::A_BAND, 32'h3000);
        rdc(dcc_pkg::A_BAND, 32'h3000);
        wr(dcc_pkg::A_CTL, 32'h10);
        rdc(dcc_pkg::A_CTL, 32'h10);
        wr(dcc_pkg::A_BAND, 32'h0);
        wr(dcc_pkg::A_BAND, 32'h10);
        rdc(dcc_pkg::A_BAND, 32'h0);
        // Short mode, acknowledged source, count of two
        wr(dcc_pkg::A_CTL, dcc_pkg::C_AD);
        wr(dcc_pkg::A_CNT, 32'h2);
        en(32'h111);
        go(6'h01);
        chk(q.size(), 32'h1);
        chk(ccnt, 32'h1);
        chk(cpu_irq_req[0], 1'b0);
        rdc(dcc_pkg::A_CNT, 32'h1);
        go(6'h01);
        rdc(dcc_pkg::A_BAND, 32'h101);
        chk(end_irq, 4'h1);
        wr(dcc_pkg::A_BAND, 32'h100);
        repeat (2) @(posedge core_clk);
        chk(end_irq, 4'h0);
        // Source left set without acknowledge
        wr(dcc_pkg::A_CNT, 32'h5);
        en(32'h010);
        go(6'h01);
        chk(q.size(), 32'h1);
        chk(ccnt, 32'h0);
        chk(cpu_irq_req[0], 1'b1);
        pulse(6'h00, 6'h01);
        wr(dcc_pkg::A_BAND, 32'h100);
        go(6'h01);
        chk(q.size(), 32'h0);
        chk(cpu_irq_req[0], 1'b1);
        pulse(6'h00, 6'h01);
        // Shared source, only enabled subs in priority order
        wr(dcc_pkg::A_CTL + 8'h04, dcc_pkg::C_AD);
        wr(dcc_pkg::A_CTL + 8'h08, dcc_pkg::C_AD);
        wr(dcc_pkg::A_CNT + 8'h04, 32'h5);
        en(32'h330);
        go(6'h01);
        chk(q.size(), 32'h2);
        chk(q[0], 32'h0);
        chk(q[1], 32'h1);
        wr(dcc_pkg::A_CTL + 8'h04, 32'h0);
        wr(dcc_pkg::A_CTL + 8'h08, 32'h0);
        foreach (uc[k])
        begin
            wr(dcc_pkg::A_CTL, uc[k]);
            en(32'h010);
            go(6'h3F);
            chk(q.size(), 32'h0);
            pulse(6'h00, 6'h3F);
        end
        // Short repeat mode reloads the low count and keeps the enable
        wr(dcc_pkg::A_CTL, 32'h21);
        wr(dcc_pkg::A_CNT, 32'h201);
        en(32'h010);
        go(6'h01);
        chk(q.size(), 32'h1);
        rdc(dcc_pkg::A_CNT, 32'h202);
        rdc(dcc_pkg::A_BAND, 32'h010);
        pulse(6'h00, 6'h01);
        // Wide mode auto-request with destination stepping
        for (int k = 0; k < 8; k++)
        begin
            wr(dcc_pkg::A_CTL, {k[2], 7'h00});
            wr(dcc_pkg::A_CTL + 8'h04, {1'b0, k[1], k[0], 1'b0, (k < 4) ? dcc_pkg::C_ACS : dcc_pkg::C_ABU});
            wr(dcc_pkg::A_CNT, 32'h3);
            wr(dcc_pkg::A_DST, 32'h1000);
            q.delete();
            tq.delete();
            en(32'h4010);
            repeat (20) @(posedge core_clk);
            chk(q.size(), 32'h3);
            chk(tq[2] - tq[0], (k < 4) ? 32'h4 : 32'h2);
            st = k[2] ? dcc_pkg::STEP_W : dcc_pkg::STEP_B;
            e = !k[0] ? 24'h001000 : (k[1] ? 24'h001000 - st - st - st : 24'h001000 + st + st + st);
            rdc(dcc_pkg::A_DST, {8'h00, e});
            rdc(dcc_pkg::A_BAND, 32'h4000);
        end
        // Wide block mode, each peripheral source
        wr(dcc_pkg::A_MODE, 32'h1);
        wr(dcc_pkg::A_CTL, 32'h0);
        for (int i = 0; i < 6; i++)
        begin
            wr(dcc_pkg::A_CTL + 8'h04, bc[i]);
            wr(dcc_pkg::A_CNT, 32'h2);
            en(32'h4210);
            go(6'h01 << i);
            chk(q.size(), 32'h1);
            chk(ccnt, 32'h1);
        end
        wr(dcc_pkg::A_MODE, 32'h0);
        // Wide channel 1 started by the request line level
        wr(dcc_pkg::A_CTL + 8'h0C, dcc_pkg::C_USB);
        wr(dcc_pkg::A_CNT + 8'h08, 32'h4);
        en(32'h8040);
        go(6'h00);
        chk(q.size(), 32'h0);
        usb <= 1'b1;
        repeat (20) @(posedge core_clk);
        usb <= 1'b0;
        chk(q.size(), 32'h4);
        chk(q[0], 32'h2);
        rdc(dcc_pkg::A_BAND, 32'h8000);
        finish_test();
    end
endmodule : test_dcc_ctrl
